// >>> vit_ctrl.v
// interrupt aggregation, pin edge detect and 12-bit free-running timer
// Operation
// - twelve-bit counter runs free, one step per microsecond.
// - tick sources come from counter bit 6 and bit 9.
// - ticks request only on rising bit transition when enabled.
// - reading low byte captures upper four bits into holding register.
// - reading upper nibble returns holding register, not live count.
// - eleven sources, each maskable, each with own vector.
// - sources: bus reset, two ticks, five endpoints, DAC, GPIO, I2C.
// - endpoint requests after host write or device send.
// - DAC pins masked individually before joining DAC request.
// - GPIO pins masked individually before joining GPIO request.
// - enabled GPIO conditions merge into one shared vector.
// - DAC trigger polarity selectable per pin.
// - GPIO trigger polarity selectable per port.
// - polarity is rising or falling edge.
`include "vit_defs.vh"
`default_nettype none
module vit_ctrl #(
  parameter DAC_W = 8,
  parameter GPIO_PORTS = 4,
  parameter [`VIT_DIV_W-1:0] TICK_DIV = `VIT_TICK_DIV
) (
  input wire sys_clk,
  input wire arst_n,
  input wire [`VIT_NSRC-1:0] srcEnable,
  input wire usbBusReset,
  input wire [4:0] epHostWrite,
  input wire [4:0] epDeviceSent,
  input wire i2cEvent,
  input wire [DAC_W-1:0] dacPin,
  input wire [DAC_W-1:0] dacPinMask,
  input wire [DAC_W-1:0] dacFallSel,
  input wire [GPIO_PORTS*8-1:0] gpioPin,
  input wire [GPIO_PORTS*8-1:0] gpioPinMask,
  input wire [GPIO_PORTS-1:0] gpioFallSel,
  input wire timerLowRead,
  input wire vecAck,
  output reg [7:0] timerLow_reg,
  output reg [3:0] timerHigh_reg,
  output reg [`VIT_NSRC-1:0] pending_reg,
  output reg irqReq_reg,
  output reg [`VIT_VEC_W-1:0] irqVec_reg
);
  localparam GW = GPIO_PORTS * `VIT_PORT_W;
  localparam NEP = `VIT_NEP;

  // lowest index wins, so bus reset outranks every other source
  function [`VIT_VEC_W-1:0] prioEnc;
    input [`VIT_NSRC-1:0] req;
    integer i;
    begin
      prioEnc = `VIT_VEC_NONE;
      for (i = `VIT_NSRC - 1; i >= 0; i = i - 1)
        if (req[i])
          prioEnc = i[`VIT_VEC_W-1:0];
    end
  endfunction

  // one pin: rising edge when fall is low, falling edge when high
  function edgeHit;
    input cur;
    input prev;
    input fall;
    begin
      if (fall)
        edgeHit = prev & ~cur;
      else
        edgeHit = cur & ~prev;
    end
  endfunction

  // two sync stages; the third only keeps the last value for edge compare
  reg [DAC_W-1:0] dacS1_reg;
  reg [DAC_W-1:0] dacS2_reg;
  reg [DAC_W-1:0] dacS3_reg;
  reg [GW-1:0] gpioS1_reg;
  reg [GW-1:0] gpioS2_reg;
  reg [GW-1:0] gpioS3_reg;
  reg busRstS1_reg;
  reg busRstS2_reg;
  reg [`VIT_DIV_W-1:0] divCnt_reg;
  reg [`VIT_DIV_W-1:0] divCnt_next;
  reg [`VIT_CNT_W-1:0] count_reg;
  reg [`VIT_CNT_W-1:0] count_next;
  reg [`VIT_CNT_W-1:0] countPrev_reg;
  reg [`VIT_NSRC-1:0] event_c;
  reg [`VIT_NSRC-1:0] ackClr_c;
  reg [`VIT_NSRC-1:0] pending_next;
  reg [`VIT_VEC_W-1:0] vec_next;
  wire usTick;
  wire [DAC_W-1:0] dacHit;
  wire [GW-1:0] gpioHit;

  // divider stands in for the 1 MHz tick; limitation: at most 256 clocks per step
  assign usTick = (divCnt_reg == TICK_DIV - `VIT_DIV_ONE);

  always @*
  begin
    if (usTick)
      divCnt_next = `VIT_DIV_ZERO;
    else
      divCnt_next = divCnt_reg + `VIT_DIV_ONE;
    count_next = count_reg + {{(`VIT_CNT_W-1){1'b0}}, usTick};
  end

  // per-pin edge detect after the sync stages
  genvar d;
  genvar g;
  generate
    for (d = 0; d < DAC_W; d = d + 1)
    begin : dacEdge
      wire pinEdge = edgeHit(dacS2_reg[d], dacS3_reg[d], dacFallSel[d]);
      assign dacHit[d] = pinEdge & dacPinMask[d];
    end
    for (g = 0; g < GW; g = g + 1)
    begin : gpioEdge
      // one polarity bit serves all pins of a port
      wire pinEdge = edgeHit(gpioS2_reg[g], gpioS3_reg[g], gpioFallSel[g / `VIT_PORT_W]);
      assign gpioHit[g] = pinEdge & gpioPinMask[g];
    end
  endgenerate

  always @*
  begin
    event_c = {`VIT_NSRC{1'b0}};
    event_c[`VIT_SRC_BUSRST] = busRstS2_reg;
    event_c[`VIT_SRC_T128] = count_reg[`VIT_TICK128_BIT] & ~countPrev_reg[`VIT_TICK128_BIT];
    event_c[`VIT_SRC_T1024] = count_reg[`VIT_TICK1024_BIT] & ~countPrev_reg[`VIT_TICK1024_BIT];
    event_c[`VIT_SRC_EP0+NEP-1:`VIT_SRC_EP0] = epHostWrite | epDeviceSent;
    event_c[`VIT_SRC_DAC] = |dacHit;
    event_c[`VIT_SRC_GPIO] = |gpioHit;
    event_c[`VIT_SRC_I2C] = i2cEvent;
  end

  // acked vector clears, but a new event in the same cycle wins
  always @*
  begin
    ackClr_c = {`VIT_NSRC{1'b0}};
    if (vecAck && irqReq_reg)
      ackClr_c[irqVec_reg] = 1'b1;
  end

  always @*
  begin
    pending_next = ((pending_reg & ~ackClr_c) | event_c) & srcEnable;
    vec_next = prioEnc(pending_next);
  end

  // pins reset high like their pull-ups, so release gives no false edge
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dacS1_reg <= {DAC_W{1'b1}};
      dacS2_reg <= {DAC_W{1'b1}};
      dacS3_reg <= {DAC_W{1'b1}};
      gpioS1_reg <= {GW{1'b1}};
      gpioS2_reg <= {GW{1'b1}};
      gpioS3_reg <= {GW{1'b1}};
      busRstS1_reg <= 1'b0;
      busRstS2_reg <= 1'b0;
    end
    else
    begin
      dacS1_reg <= dacPin;
      dacS2_reg <= dacS1_reg;
      dacS3_reg <= dacS2_reg;
      gpioS1_reg <= gpioPin;
      gpioS2_reg <= gpioS1_reg;
      gpioS3_reg <= gpioS2_reg;
      busRstS1_reg <= usbBusReset;
      busRstS2_reg <= busRstS1_reg;
    end
  end

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      divCnt_reg <= `VIT_DIV_ZERO;
      count_reg <= {`VIT_CNT_W{1'b0}};
      countPrev_reg <= {`VIT_CNT_W{1'b0}};
    end
    else
    begin
      divCnt_reg <= divCnt_next;
      count_reg <= count_next;
      countPrev_reg <= count_reg;
    end
  end

  // high nibble loads only on a low-byte read, so a later carry stays hidden
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      timerLow_reg <= {`VIT_LOW_W{1'b0}};
      timerHigh_reg <= {(`VIT_CNT_W-`VIT_LOW_W){1'b0}};
    end
    else
    begin
      timerLow_reg <= count_reg[`VIT_LOW_W-1:0];
      if (timerLowRead)
        timerHigh_reg <= count_reg[`VIT_CNT_W-1:`VIT_LOW_W];
    end
  end

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pending_reg <= {`VIT_NSRC{1'b0}};
      irqReq_reg <= 1'b0;
      irqVec_reg <= `VIT_VEC_NONE;
    end
    else
    begin
      pending_reg <= pending_next;
      irqReq_reg <= |pending_next;
      irqVec_reg <= vec_next;
    end
  end
endmodule
`default_nettype wire

// >>> vit_defs.vh
// constants for the vectored interrupt and timer block
`ifndef VIT_DEFS_VH
`define VIT_DEFS_VH
`define VIT_CNT_W 12
`define VIT_TICK128_BIT 6
`define VIT_TICK1024_BIT 9
`define VIT_NSRC 11
`define VIT_VEC_W 4
`define VIT_DIV_W 8
`define VIT_TICK_DIV 8'hc8
`define VIT_DIV_ZERO 8'h00
`define VIT_DIV_ONE 8'h01
`define VIT_PORT_W 8
`define VIT_NEP 5
`define VIT_LOW_W 8
`define VIT_SRC_BUSRST 0
`define VIT_SRC_T128 1
`define VIT_SRC_T1024 2
`define VIT_SRC_EP0 3
`define VIT_SRC_DAC 8
`define VIT_SRC_GPIO 9
`define VIT_SRC_I2C 10
`define VIT_VEC_NONE 4'hf
`endif

// >>> vit_ctrl_props.sv
// checker on vit_ctrl ports
`default_nettype none
module vit_ctrl_props (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [10:0] srcEnable,
  input wire logic usbBusReset,
  input wire logic [4:0] epHostWrite,
  input wire logic timerLowRead,
  input wire logic [7:0] timerLow_reg,
  input wire logic [3:0] timerHigh_reg,
  input wire logic [10:0] pending_reg,
  input wire logic irqReq_reg,
  input wire logic [3:0] irqVec_reg
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  property p_any; irqReq_reg == |pending_reg; endproperty
  a_any: assert property (p_any) else $error("req");
  property p_dis; (pending_reg & ~$past(srcEnable)) == 11'h0; endproperty
  a_dis: assert property (p_dis) else $error("mask");
  property p_pri; irqReq_reg |-> pending_reg[irqVec_reg]
    && (pending_reg & ((11'h1 << irqVec_reg) - 11'h1)) == 11'h0; endproperty
  a_pri: assert property (p_pri) else $error("prio");
  property p_ep; epHostWrite[0] && srcEnable[3] |=> pending_reg[3]; endproperty
  a_ep: assert property (p_ep) else $error("ep");
  property p_bus; usbBusReset && srcEnable[0] |-> ##[1:4] pending_reg[0]; endproperty
  a_bus: assert property (p_bus) else $error("bus");
  property p_tick; $rose(timerLow_reg[6]) && srcEnable[1] |-> ##[0:2] pending_reg[1]; endproperty
  a_tick: assert property (p_tick) else $error("tick");
  property p_hold; !timerLowRead |=> $stable(timerHigh_reg); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_cnt; $changed(timerLow_reg) |-> timerLow_reg == 8'($past(timerLow_reg) + 8'h1);
  endproperty
  a_cnt: assert property (p_cnt) else $error("count");
endmodule
bind vit_ctrl vit_ctrl_props u_props (.*);
`default_nettype wire

// >>> vit_core_model.sv
// core stand-in accepting one vector at a time
`default_nettype none
module vit_core_model (
  input wire logic sys_clk,
  input wire logic irqReq_reg,
  input wire logic ackOn,
  output var logic vecAck
);
  timeunit 1ns;
  timeprecision 100ps;
  initial vecAck = 1'b0;
  // ackOn low stalls the core
  always @(posedge sys_clk) vecAck <= #1 ackOn && irqReq_reg && !vecAck;
endmodule
`default_nettype wire

// >>> tb.sv
// testbench for vit_ctrl
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 0, arst_n = 0, usbBusReset = 0, timerLowRead = 0, i2cEvent = 0, ackOn = 0;
  logic vecAck, irqReq_reg;
  logic [10:0] srcEnable = 0, pending_reg;
  logic [4:0] epHostWrite = 0, epDeviceSent = 0;
  logic [7:0] dacPin = 8'hff, dacPinMask = 0, dacFallSel = 0, timerLow_reg;
  logic [31:0] gpioPin = '1, gpioPinMask = 0;
  logic [3:0] gpioFallSel = 0, timerHigh_reg, irqVec_reg;
  int fails = 0, total_checks = 0, n;
  always #2.5 sys_clk = ~sys_clk;
  // two clocks per microsecond so the 1024 tick fits the run
  vit_ctrl #(.TICK_DIV(8'h02)) u_vit_ctrl (.*);
  vit_core_model u_vit_core_model (.*);
  task cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task ck(input logic c);
    total_checks++;
    if (c !== 1'b1) fails++;
    if (c !== 1'b1) $display("Error %0t mismatch", $time);
  endtask
  task t_ep;
    srcEnable = 11'h7f8; epHostWrite = 5'h01; epDeviceSent = 5'h04; i2cEvent = 1; cyc(1);
    epHostWrite = 0; epDeviceSent = 0; i2cEvent = 0; cyc(1);
    ck(pending_reg === 11'h428);
    ck(irqVec_reg === 4'h3);
    ackOn = 1; cyc(8); ackOn = 0;
    ck(irqReq_reg === 1'b0);
    srcEnable = 11'h001; usbBusReset = 1; cyc(4);
    ck(pending_reg === 11'h001);
    usbBusReset = 0; srcEnable = 0; cyc(1);
    $display("ep done");
  endtask
  task t_pin;
    srcEnable = 11'h300; dacPinMask = 8'h01; dacFallSel = 8'h01; gpioPinMask = 32'h100;
    dacPin = 8'hfd; cyc(5); ck(pending_reg === 11'h0);
    dacPin = 8'hfc; cyc(5); ck(pending_reg === 11'h100);
    srcEnable = 11'h200; dacPin = 8'hff; gpioPin = ~32'h300; cyc(5);
    ck(pending_reg === 11'h0);
    gpioPin = ~32'h100; cyc(5); ck(pending_reg === 11'h0);
    gpioPin = '1; cyc(5); ck(pending_reg === 11'h200);
    srcEnable = 0; cyc(1); srcEnable = 11'h200; gpioFallSel = 4'h1; gpioPin = ~32'h100; cyc(5);
    ck(pending_reg === 11'h0);
    gpioFallSel = 4'h2; gpioPin = '1; cyc(2); gpioPin = ~32'h100; cyc(5);
    ck(pending_reg === 11'h200);
    srcEnable = 0; gpioPin = '1; cyc(1);
    $display("pin done");
  endtask
  task t_tim;
    repeat (3)
    begin
      srcEnable = 11'h002; n = 0;
      while (pending_reg[1] !== 1'b1 && n < 1000) begin cyc(1); n++; end
      ck(n < 1000);
      if (n >= 1000) summarize;
      srcEnable = 0; cyc(1);
    end
    timerLowRead = 1; cyc(1); timerLowRead = 0;
    ck(timerHigh_reg === 4'h1);
    ck(timerLow_reg[7:6] === 2'b01);
    srcEnable = 11'h004; n = 0;
    while (pending_reg[2] !== 1'b1 && n < 1000) begin cyc(1); n++; end
    ck(n < 1000);
    if (n >= 1000) summarize;
    ck(timerHigh_reg === 4'h1);
    timerLowRead = 1; cyc(1); timerLowRead = 0;
    ck(timerHigh_reg === 4'h2 && timerLow_reg[7:1] === 7'h00);
    srcEnable = 0; cyc(1);
    $display("timer done");
  endtask
  task t_rst;
    srcEnable = 11'h400; i2cEvent = 1; cyc(1); i2cEvent = 0; cyc(1);
    ck(pending_reg === 11'h400 && irqVec_reg === 4'ha);
    arst_n = 0; cyc(1);
    ck(pending_reg === 11'h0 && irqReq_reg === 1'b0 && irqVec_reg === 4'hf);
    ck(timerHigh_reg === 4'h0 && timerLow_reg === 8'h00);
    srcEnable = 0; arst_n = 1; cyc(2);
    ck(irqReq_reg === 1'b0);
    $display("reset done");
  endtask
  task summarize;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial
  begin
    cyc(5); arst_n = 1; cyc(1);
    t_ep; t_pin; t_tim; t_rst; summarize;
  end
endmodule
`default_nettype wire
